//--- logic/cps_sequencer.v
// sequencer core: four-state fetch/decode/execute/interrupt engine, data map,
// core system registers and the 48-nibble data memory
// assumes the program store presents rom_data one cycle after rom_addr settles,
// and the peripheral registers answer per_rdata combinationally from per_addr
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.vh"
module cps_sequencer #(
  parameter STACK_DEPTH = 4,
  parameter RAM_WORDS = 48
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // program store
  output wire [9:0] rom_addr,
  input wire [15:0] rom_data,
  // peripheral system registers
  output wire [4:0] per_addr,
  output wire per_rd,
  output wire per_we,
  output wire [3:0] per_wdata,
  input wire [3:0] per_rdata,
  // interrupt events, one-cycle pulses
  input wire timer_overflow,
  input wire port_edge_source,
  // core state
  output wire [11:0] prog_counter,
  output wire page_select_bit,
  output wire [3:0] accumulator,
  output wire carry_flag,
  output wire [2:0] stack_depth
);
  localparam S_FETCH = 4'b0001;
  localparam S_DECODE = 4'b0010;
  localparam S_EXEC = 4'b0100;
  localparam S_IRQ = 4'b1000;

  reg [3:0] state_r;
  reg [11:0] pc_r;
  reg [9:0] rom_addr_r;
  reg [15:0] instr_r;
  reg [9:0] eaddr_r;
  reg [3:0] accumulator_r;
  reg carry_flag_r;
  reg [4:0] per_addr_r;
  reg per_rd_r;
  reg per_we_r;
  reg [3:0] per_wdata_r;
  reg timer_irq_enable_r;
  reg port_irq_enable_r;
  reg timer_irq_request_r;
  reg port_irq_request_r;
  reg [3:0] table_jump_nibble_r;
  reg [3:0] index_pointer_low_r;
  reg [2:0] index_pointer_mid_r;
  reg [2:0] index_pointer_high_r;
  reg [3:0] ram [0:RAM_WORDS-1];

  reg [3:0] mem_rd;
  reg [3:0] alu_fn;
  reg [3:0] alu_a;
  reg [3:0] alu_b;
  reg acc_we;
  reg mem_we;
  reg [11:0] pc_nxt;
  reg stk_push;
  reg stk_pop;
  reg [12:0] push_data;
  wire [3:0] alu_res;
  wire alu_carry;
  wire alu_carry_we;
  wire [12:0] stk_top;

  function is_ram;
    input [9:0] a;
    begin
      is_ram = (a >= `CPS_A_RAM_FIRST) && (a <= `CPS_A_RAM_LAST);
    end
  endfunction

  // system addresses not held here go out to the peripheral port
  function is_ext;
    input [9:0] a;
    begin
      is_ext = (a <= `CPS_A_SYS_LAST) && (a != `CPS_A_IRQ_EN) && (a != `CPS_A_IRQ_REQ) &&
        ((a < `CPS_A_TJN) || (a > `CPS_A_IXH));
    end
  endfunction

  // decode straight from the store so the peripheral address is ready in execute
  wire [3:0] dec_op = rom_data[`CPS_OP_MSB:`CPS_OP_LSB];
  wire [9:0] dec_dir = {3'b000, rom_data[`CPS_AD_MSB:0]};
  wire [9:0] dec_addr = (dec_dir == `CPS_A_INDIR) ?
    {index_pointer_high_r, index_pointer_mid_r, index_pointer_low_r} : dec_dir;
  wire dec_mem = (dec_op == `CPS_OP_MEM) || ((dec_op >= `CPS_OP_ADI) && (dec_op <= `CPS_OP_ORIM));

  wire [3:0] op = instr_r[`CPS_OP_MSB:`CPS_OP_LSB];
  wire [3:0] fn = instr_r[`CPS_FN_MSB:`CPS_FN_LSB];
  wire [9:0] ram_off = eaddr_r - `CPS_A_RAM_FIRST;
  wire [5:0] ram_idx = ram_off[5:0];
  wire exec = (state_r == S_EXEC);
  wire sys_we = exec && mem_we;
  wire irq_tmr = timer_irq_enable_r && timer_irq_request_r;
  wire irq_port = port_irq_enable_r && port_irq_request_r;
  // timer wins when both are pending
  wire [11:0] irq_vec = irq_tmr ? `CPS_VEC_TMR : `CPS_VEC_PORT;
  // page bit is held, not carried into
  wire [11:0] pc_inc = {pc_r[11], pc_r[10:0] + 11'h001};
  wire [11:0] br_pc = {pc_r[11], 1'b0, instr_r[9:0]};

  // one flat map, so every location is one direct operand away
  always @*
  begin
    mem_rd = 4'h0;
    if (is_ram(eaddr_r))
      mem_rd = ram[ram_idx];
    else if (is_ext(eaddr_r))
      mem_rd = per_rdata;
    else
      case (eaddr_r)
        `CPS_A_IRQ_EN: mem_rd = {1'b0, timer_irq_enable_r, 1'b0, port_irq_enable_r};
        `CPS_A_IRQ_REQ: mem_rd = {1'b0, timer_irq_request_r, 1'b0, port_irq_request_r};
        `CPS_A_TJN: mem_rd = table_jump_nibble_r;
        `CPS_A_IXL: mem_rd = index_pointer_low_r;
        `CPS_A_IXM: mem_rd = {1'b0, index_pointer_mid_r};
        `CPS_A_IXH: mem_rd = {1'b0, index_pointer_high_r};
        default: mem_rd = 4'h0;
      endcase
  end

  always @*
  begin
    alu_fn = fn;
    alu_a = accumulator_r;
    alu_b = mem_rd;
    acc_we = 1'b0;
    mem_we = 1'b0;
    case (op)
      `CPS_OP_MEM:
      begin
        acc_we = (fn != `CPS_F_STA);
        mem_we = instr_r[`CPS_ST_BIT] || (fn == `CPS_F_STA);
      end
      `CPS_OP_ADI, `CPS_OP_SBI:
      begin
        alu_fn = (op == `CPS_OP_ADI) ? `CPS_F_ADD : `CPS_F_SUB;
        alu_a = mem_rd;
        alu_b = fn;
        acc_we = 1'b1;
      end
      `CPS_OP_ANDIM, `CPS_OP_EORIM, `CPS_OP_ORIM:
      begin
        alu_fn = (op == `CPS_OP_ANDIM) ? `CPS_F_AND : (op == `CPS_OP_EORIM) ? `CPS_F_XOR : `CPS_F_OR;
        alu_a = mem_rd;
        alu_b = fn;
        acc_we = 1'b1;
        mem_we = 1'b1;
      end
      `CPS_OP_LDI, `CPS_OP_RETV:
      begin
        alu_fn = `CPS_F_LDA;
        alu_b = instr_r[3:0];
        acc_we = 1'b1;
      end
      default: alu_fn = fn;
    endcase
  end

  always @*
  begin
    pc_nxt = pc_inc;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    push_data = {carry_flag_r, pc_inc};
    if (state_r == S_IRQ)
    begin
      pc_nxt = irq_vec;
      stk_push = 1'b1;
      push_data = {carry_flag_r, pc_r};
    end
    else if (exec)
      case (op)
        `CPS_OP_BIT:
          if (accumulator_r[instr_r[11:10]])
            pc_nxt = br_pc;
        `CPS_OP_BAZ:
          if (accumulator_r == 4'h0)
            pc_nxt = br_pc;
        `CPS_OP_BC:
          if (carry_flag_r)
            pc_nxt = br_pc;
        `CPS_OP_JMP: pc_nxt = instr_r[11:0];
        `CPS_OP_CALL:
        begin
          pc_nxt = instr_r[11:0];
          stk_push = 1'b1;
        end
        `CPS_OP_RETV, `CPS_OP_RETI:
        begin
          pc_nxt = stk_top[11:0];
          stk_pop = 1'b1;
        end
        default: pc_nxt = pc_inc;
      endcase
  end

  cps_alu u_alu (
    .func(alu_fn),
    .a(alu_a),
    .b(alu_b),
    .cin(carry_flag_r),
    .res(alu_res),
    .cout(alu_carry),
    .carry_we(alu_carry_we)
  );

  cps_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(13),
    .CNTW(3)
  ) u_stack (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(push_data),
    .top_data(stk_top),
    .depth(stack_depth)
  );

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_FETCH;
      pc_r <= `CPS_VEC_RESET;
      rom_addr_r <= 10'h000;
      instr_r <= 16'h0000;
      eaddr_r <= 10'h000;
      accumulator_r <= `CPS_RST_NIB;
      carry_flag_r <= 1'b0;
      per_addr_r <= 5'h00;
      per_rd_r <= 1'b0;
      per_we_r <= 1'b0;
      per_wdata_r <= `CPS_RST_NIB;
    end
    else
    begin
      per_we_r <= 1'b0;
      case (state_r)
        S_FETCH:
          state_r <= (irq_tmr || irq_port) ? S_IRQ : S_DECODE;
        S_DECODE:
        begin
          instr_r <= rom_data;
          eaddr_r <= dec_addr;
          per_addr_r <= dec_addr[4:0];
          per_rd_r <= dec_mem && is_ext(dec_addr);
          state_r <= S_EXEC;
        end
        S_EXEC:
        begin
          per_rd_r <= 1'b0;
          if (acc_we)
            accumulator_r <= alu_res;
          if (alu_carry_we && (acc_we || mem_we))
            carry_flag_r <= alu_carry;
          if (op == `CPS_OP_RETI)
            carry_flag_r <= stk_top[12];
          if (mem_we && is_ext(eaddr_r))
          begin
            per_we_r <= 1'b1;
            per_wdata_r <= alu_res;
          end
          pc_r <= pc_nxt;
          rom_addr_r <= pc_nxt[9:0];
          state_r <= S_FETCH;
        end
        S_IRQ:
        begin
          pc_r <= pc_nxt;
          rom_addr_r <= pc_nxt[9:0];
          state_r <= S_FETCH;
        end
        default: state_r <= S_FETCH;
      endcase
    end
  end

  // core system registers; hardware set wins over a software clear
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_irq_enable_r <= 1'b0;
      port_irq_enable_r <= 1'b0;
      timer_irq_request_r <= 1'b0;
      port_irq_request_r <= 1'b0;
      table_jump_nibble_r <= `CPS_RST_NIB;
      index_pointer_low_r <= `CPS_RST_NIB;
      index_pointer_mid_r <= 3'h0;
      index_pointer_high_r <= 3'h0;
    end
    else
    begin
      if (sys_we)
        case (eaddr_r)
          `CPS_A_IRQ_EN:
          begin
            timer_irq_enable_r <= alu_res[`CPS_B_TMR];
            port_irq_enable_r <= alu_res[`CPS_B_PORT];
          end
          `CPS_A_IRQ_REQ:
          begin
            timer_irq_request_r <= alu_res[`CPS_B_TMR];
            port_irq_request_r <= alu_res[`CPS_B_PORT];
          end
          `CPS_A_TJN: table_jump_nibble_r <= alu_res;
          `CPS_A_IXL: index_pointer_low_r <= alu_res;
          `CPS_A_IXM: index_pointer_mid_r <= alu_res[2:0];
          `CPS_A_IXH: index_pointer_high_r <= alu_res[2:0];
          default: table_jump_nibble_r <= table_jump_nibble_r;
        endcase
      // entry acknowledges only the source that was taken
      if (state_r == S_IRQ && irq_tmr)
        timer_irq_request_r <= 1'b0;
      else if (state_r == S_IRQ)
        port_irq_request_r <= 1'b0;
      if (timer_overflow)
        timer_irq_request_r <= 1'b1;
      if (port_edge_source)
        port_irq_request_r <= 1'b1;
    end
  end

  // data nibbles carry no reset; software initialises them
  always @(posedge clk_sys)
  begin
    if (sys_we && is_ram(eaddr_r))
      ram[ram_idx] <= alu_res;
  end

  assign rom_addr = rom_addr_r;
  assign per_addr = per_addr_r;
  assign per_rd = per_rd_r;
  assign per_we = per_we_r;
  assign per_wdata = per_wdata_r;
  assign prog_counter = pc_r;
  assign page_select_bit = pc_r[11];
  assign accumulator = accumulator_r;
  assign carry_flag = carry_flag_r;
endmodule
`default_nettype wire

//--- logic/cps_defs.vh
// sequencer constants: data map, vectors, opcodes, alu functions, reset values
// assumes it is included by its bare name from the files under logic/
// How it works
// - program counter is a page bit over an 11-bit ripple counter, addressing 1K words.
// - counter steps by one per instruction unless a taken branch, jump, call, return, interrupt or reset loads it.
// - jumps and calls load the counter with the target carried in the instruction.
// - calls and interrupts push carry; interrupt return restores it, value return does not.
// - stack holds four 13-bit entries: carry on top, program counter below.
// - return instructions pop entries into the counter, last in first out.
// - calls and interrupts share four levels; a fifth push drops the oldest entry.
// - program space is 1024 sixteen-bit words, addresses 0x000 to 0x3FF.
// - vectors: reset 0x000, timer 0x002, port edge 0x004; odd slots unused.
// - data addresses 0x00-0x1F are system registers, 0x20-0x4F are 48 nibbles.
// - every register and nibble is reached directly by one instruction, no banking.
// - 4-bit accumulator takes alu results and moves data to registers and memory.
// - alu: add/sub with and without carry, decimal adjust, logic, right shift.
// - carry captures overflow or borrow of every arithmetic operation.
// - indirect address joins 4-bit low, 3-bit middle, 3-bit high pointer nibbles.
// - chip reset clears both enable flags and both request flags.
`ifndef CPS_DEFS_VH
`define CPS_DEFS_VH
// data map
`define CPS_A_IRQ_EN 10'h000
`define CPS_A_IRQ_REQ 10'h001
`define CPS_A_TJN 10'h00E
`define CPS_A_INDIR 10'h00F
`define CPS_A_IXL 10'h010
`define CPS_A_IXM 10'h011
`define CPS_A_IXH 10'h012
`define CPS_A_SYS_LAST 10'h01F
`define CPS_A_RAM_FIRST 10'h020
`define CPS_A_RAM_LAST 10'h04F
// flag bit positions in the enable and request registers
`define CPS_B_TMR 2
`define CPS_B_PORT 0
// reset values and vectors
`define CPS_RST_NIB 4'h0
`define CPS_VEC_RESET 12'h000
`define CPS_VEC_TMR 12'h002
`define CPS_VEC_PORT 12'h004
// instruction fields
`define CPS_OP_MSB 15
`define CPS_OP_LSB 12
`define CPS_FN_MSB 11
`define CPS_FN_LSB 8
`define CPS_ST_BIT 7
`define CPS_AD_MSB 6
// opcodes
`define CPS_OP_NOP 4'h0
`define CPS_OP_MEM 4'h1
`define CPS_OP_ADI 4'h2
`define CPS_OP_SBI 4'h3
`define CPS_OP_ANDIM 4'h4
`define CPS_OP_EORIM 4'h5
`define CPS_OP_ORIM 4'h6
`define CPS_OP_BIT 4'h7
`define CPS_OP_BAZ 4'h8
`define CPS_OP_BC 4'h9
`define CPS_OP_CALL 4'hA
`define CPS_OP_JMP 4'hB
`define CPS_OP_RETV 4'hC
`define CPS_OP_RETI 4'hD
`define CPS_OP_LDI 4'hE
// alu functions
`define CPS_F_ADC 4'h0
`define CPS_F_ADD 4'h1
`define CPS_F_SBC 4'h2
`define CPS_F_SUB 4'h3
`define CPS_F_AND 4'h4
`define CPS_F_XOR 4'h5
`define CPS_F_OR 4'h6
`define CPS_F_DADJA 4'h7
`define CPS_F_DADJS 4'h8
`define CPS_F_SRL 4'h9
`define CPS_F_LDA 4'hA
`define CPS_F_STA 4'hB
`endif

//--- logic/cps_alu.v
// combinational 4-bit alu with carry
// assumes the caller gates carry_we with an actual write-back
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.vh"
module cps_alu (
  // operation
  input wire [3:0] func,
  input wire [3:0] a,
  input wire [3:0] b,
  input wire cin,
  // result
  output reg [3:0] res,
  output reg cout,
  output reg carry_we
);
  reg [4:0] sum;
  reg [4:0] tmp;
  reg arith;

  function [4:0] add5;
    input [3:0] x;
    input [3:0] y;
    input c;
    begin
      add5 = {1'b0, x} + {1'b0, y} + {4'h0, c};
    end
  endfunction

  // carry set means no borrow on subtraction
  always @*
  begin
    sum = 5'h00;
    tmp = 5'h00;
    arith = 1'b1;
    res = a;
    case (func)
      `CPS_F_ADC: sum = add5(a, b, cin);
      `CPS_F_ADD: sum = add5(a, b, 1'b0);
      `CPS_F_SBC: sum = add5(a, ~b, cin);
      `CPS_F_SUB: sum = add5(a, ~b, 1'b1);
      `CPS_F_DADJA:
      begin
        tmp = add5(a, 4'h6, 1'b0);
        sum = (cin || a > 4'h9) ? {1'b1, tmp[3:0]} : {1'b0, a};
      end
      `CPS_F_DADJS:
      begin
        tmp = add5(a, 4'hA, 1'b0);
        sum = cin ? {1'b1, a} : {1'b0, tmp[3:0]};
      end
      default: arith = 1'b0;
    endcase
    case (func)
      `CPS_F_AND: res = a & b;
      `CPS_F_XOR: res = a ^ b;
      `CPS_F_OR: res = a | b;
      `CPS_F_SRL: res = {1'b0, a[3:1]};
      `CPS_F_LDA: res = b;
      `CPS_F_STA: res = a;
      default: res = sum[3:0];
    endcase
    cout = arith ? sum[4] : cin;
    carry_we = arith;
  end
endmodule
`default_nettype wire

//--- logic/cps_stack.v
// shift-register return stack, newest entry at index 0
// assumes push and pop are never asserted together
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.vh"
module cps_stack #(
  parameter DEPTH = 4,
  parameter WIDTH = 13,
  parameter CNTW = 3
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // control
  input wire push,
  input wire pop,
  input wire [WIDTH-1:0] push_data,
  // state
  output wire [WIDTH-1:0] top_data,
  output reg [CNTW-1:0] depth
);
  reg [WIDTH-1:0] entry_r [0:DEPTH-1];
  integer i;

  assign top_data = entry_r[0];

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        entry_r[i] <= {WIDTH{1'b0}};
      depth <= {CNTW{1'b0}};
    end
    else if (push)
    begin
      // the oldest entry falls off the bottom
      for (i = DEPTH - 1; i > 0; i = i - 1)
        entry_r[i] <= entry_r[i-1];
      entry_r[0] <= push_data;
      if (depth != DEPTH[CNTW-1:0])
        depth <= depth + {{(CNTW-1){1'b0}}, 1'b1};
    end
    else if (pop)
    begin
      for (i = 0; i < DEPTH - 1; i = i + 1)
        entry_r[i] <= entry_r[i+1];
      entry_r[DEPTH-1] <= {WIDTH{1'b0}};
      if (depth != {CNTW{1'b0}})
        depth <= depth - {{(CNTW-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

//--- bench/cps_seq_chk.sv
// concurrent checks on the sequencer's ports
// assumes it is bound onto cps_sequencer; one clock domain
`timescale 1ns/1ps
`default_nettype none
module cps_seq_chk #(
  parameter STACK_DEPTH = 4,
  parameter RAM_WORDS = 48
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // program store
  input wire logic [9:0] rom_addr,
  input wire logic [15:0] rom_data,
  // peripheral port
  input wire logic [4:0] per_addr,
  input wire logic per_rd,
  input wire logic per_we,
  input wire logic [3:0] per_wdata,
  input wire logic [3:0] per_rdata,
  // events
  input wire logic timer_overflow,
  input wire logic port_edge_source,
  // core state
  input wire logic [11:0] prog_counter,
  input wire logic page_select_bit,
  input wire logic [3:0] accumulator,
  input wire logic carry_flag,
  input wire logic [2:0] stack_depth
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // flags, table nibble and pointers live inside the core
  function automatic logic core_local(input logic [4:0] a);
    core_local = a < 5'h02 || (a > 5'h0D && a < 5'h13);
  endfunction
  chk_rom_follows_pc: assert property (rom_addr == prog_counter[9:0])
    else $error("rom address differs from counter");
  chk_page_bit_mirror: assert property (page_select_bit == prog_counter[11])
    else $error("page bit differs from counter top bit");
  chk_depth_bound: assert property (stack_depth <= STACK_DEPTH)
    else $error("stack depth above four");
  chk_pc_holds: assert property ($changed(prog_counter) |=> $stable(prog_counter))
    else $error("counter moved on consecutive clocks");
  chk_depth_step: assert property ($changed(stack_depth) |->
    stack_depth == $past(stack_depth) + 3'h1 || $past(stack_depth) == stack_depth + 3'h1)
    else $error("stack depth jumped by more than one");
  chk_depth_with_pc: assert property ($changed(stack_depth) |-> $changed(prog_counter))
    else $error("stack moved without a counter load");
  chk_reset_entry: assert property (!$past(reset_n) |-> prog_counter == 12'h000 && stack_depth == 3'h0)
    else $error("counter or stack not clear after reset");
  chk_we_outside: assert property (per_we |-> !core_local(per_addr))
    else $error("core register write leaked to peripheral port");
  chk_rd_single: assert property (per_rd |-> !core_local(per_addr) ##1 !per_rd)
    else $error("peripheral read wrong address or too long");
  chk_we_spacing: assert property ($rose(per_we) |=> !per_we [*2])
    else $error("peripheral writes too close");
  chk_wdata_hold: assert property (!per_we |-> $stable(per_wdata))
    else $error("write data moved without a write");
  cover property (stack_depth == 3'h4);
  cover property (prog_counter == 12'h002);
  cover property (prog_counter == 12'h004);
  cover property (per_we);
endmodule
bind cps_sequencer cps_seq_chk #(.STACK_DEPTH(STACK_DEPTH), .RAM_WORDS(RAM_WORDS)) cps_seq_chk_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .rom_addr(rom_addr), .rom_data(rom_data), .per_addr(per_addr),
  .per_rd(per_rd), .per_we(per_we), .per_wdata(per_wdata), .per_rdata(per_rdata),
  .timer_overflow(timer_overflow), .port_edge_source(port_edge_source), .prog_counter(prog_counter),
  .page_select_bit(page_select_bit), .accumulator(accumulator), .carry_flag(carry_flag),
  .stack_depth(stack_depth));
`default_nettype wire

//--- bench/cps_prog_model.sv
// program store and peripheral register file facing the sequencer
// assumes the bench fills the store before reset is released
`timescale 1ns/1ps
`default_nettype none
module cps_prog_model (
  // clock
  input wire logic clk_sys,
  // program store
  input wire logic [9:0] rom_addr,
  output logic [15:0] rom_data,
  // peripheral registers
  input wire logic [4:0] per_addr,
  input wire logic per_rd,
  input wire logic per_we,
  input wire logic [3:0] per_wdata,
  output logic [3:0] per_rdata
);
  logic [15:0] rom [0:1023];
  logic [3:0] regs [0:31];
  // word follows the address one clock later, as a synchronous store would
  always @(posedge clk_sys)
  begin
    rom_data <= rom[rom_addr];
    if (per_we)
      regs[per_addr] <= per_wdata;
  end
  // scrambled outside a read so a stray sample never matches by luck
  assign per_rdata = per_rd ? regs[per_addr] : ~regs[per_addr];
  initial
  begin
    foreach (regs[i]) regs[i] = 4'h0;
  end
endmodule
`default_nettype wire

//--- bench/cps_sequencer_bench.sv
// self-checking bench: two programs, state checked at chosen addresses
// assumes design, partner model and checker are compiled together
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer_bench;
  logic clk_sys, reset_n, timer_overflow, port_edge_source, per_rd, per_we, page_select_bit, carry_flag;
  logic [9:0] rom_addr;
  logic [15:0] rom_data;
  logic [4:0] per_addr;
  logic [3:0] per_wdata, per_rdata, accumulator;
  logic [11:0] prog_counter;
  logic [2:0] stack_depth;
  int fails, n_checks;
  int cycles = 0;
  // {address, word}; five nested calls on purpose to overrun the stack
  logic [27:0] prog [47] = '{
    28'h000B010, 28'h002B030, 28'h004D000, 28'h010E009, 28'h0111BA0, 28'h0121120,
    28'h0131700, 28'h0149016, 28'h015E00F, 28'h0161900, 28'h0175F20, 28'h0182B20,
    28'h019A100, 28'h100E000, 28'h1011320, 28'h102A200, 28'h200A300, 28'h300A380,
    28'h380A3C0, 28'h3C0C003, 28'h381C004, 28'h301C005, 28'h201C006, 28'h103B020,
    28'h020E00F, 28'h0211120, 28'h022E004, 28'h0231B80, 28'h024B024, 28'h030E000,
    28'h0311320, 28'h032D000, 28'h0401A01, 28'h041E006, 28'h0421B88, 28'h0431A08,
    28'h044E002, 28'h0451B91, 28'h046E005, 28'h0471B90, 28'h048E00C, 28'h0491B8F,
    28'h04A1A25, 28'h04B1A60, 28'h04CE001, 28'h04D1B80, 28'h04EB04E};
  cps_sequencer cps_sequencer_inst (.clk_sys(clk_sys), .reset_n(reset_n), .rom_addr(rom_addr),
    .rom_data(rom_data), .per_addr(per_addr), .per_rd(per_rd), .per_we(per_we), .per_wdata(per_wdata),
    .per_rdata(per_rdata), .timer_overflow(timer_overflow), .port_edge_source(port_edge_source),
    .prog_counter(prog_counter), .page_select_bit(page_select_bit), .accumulator(accumulator),
    .carry_flag(carry_flag), .stack_depth(stack_depth));
  cps_prog_model cps_prog_model_inst (.clk_sys(clk_sys), .rom_addr(rom_addr), .rom_data(rom_data),
    .per_addr(per_addr), .per_rd(per_rd), .per_we(per_we), .per_wdata(per_wdata), .per_rdata(per_rdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task stop_test();
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a hang is cut well past the few hundred clocks both programs need
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fails++;
      stop_test();
    end
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for the counter to reach pc, then compare the core state
  task at(input logic [11:0] pc, input logic [3:0] a, input logic c, input logic [2:0] d);
    int i;
    i = 0;
    do
    begin
      @(negedge clk_sys);
      i++;
    end
    while (prog_counter !== pc && i < 400);
    chk(prog_counter, pc);
    chk({8'h00, accumulator}, {8'h00, a});
    chk({11'h000, carry_flag}, {11'h000, c});
    chk({9'h000, stack_depth}, {9'h000, d});
  endtask
  task pulse(input logic tmr);
    @(posedge clk_sys);
    timer_overflow <= tmr;
    port_edge_source <= !tmr;
    @(posedge clk_sys);
    timer_overflow <= 1'b0;
    port_edge_source <= 1'b0;
  endtask
  initial
  begin
    reset_n = 1'b0;
    timer_overflow = 1'b0;
    port_edge_source = 1'b0;
    fails = 0;
    n_checks = 0;
    for (int i = 0; i < 1024; i++) cps_prog_model_inst.rom[i] = 16'h0000;
    foreach (prog[i]) cps_prog_model_inst.rom[prog[i][25:16]] = prog[i][15:0];
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    at(12'h016, 4'h8, 1'b1, 3'h0);
    at(12'h019, 4'h1, 1'b1, 3'h0);
    at(12'h3C0, 4'hA, 1'b0, 3'h4);
    at(12'h381, 4'h3, 1'b0, 3'h3);
    at(12'h103, 4'h6, 1'b0, 3'h0);
    at(12'h024, 4'h4, 1'b1, 3'h0);
    pulse(1'b1);
    at(12'h002, 4'h4, 1'b1, 3'h1);
    at(12'h032, 4'hA, 1'b0, 3'h1);
    at(12'h024, 4'hA, 1'b1, 3'h0);
    pulse(1'b0);
    repeat (40) @(negedge clk_sys);
    chk(prog_counter, 12'h024);
    chk({9'h000, stack_depth}, 12'h000);
    // second program behind a mid-run reset; the port request left pending must vanish
    @(posedge clk_sys);
    reset_n <= 1'b0;
    cps_prog_model_inst.rom[0] = 16'hB040;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    at(12'h041, 4'h0, 1'b0, 3'h0);
    at(12'h044, 4'h6, 1'b0, 3'h0);
    at(12'h04B, 4'hC, 1'b0, 3'h0);
    at(12'h04C, 4'h0, 1'b0, 3'h0);
    at(12'h04E, 4'h1, 1'b0, 3'h0);
    pulse(1'b0);
    at(12'h004, 4'h1, 1'b0, 3'h1);
    at(12'h04E, 4'h1, 1'b0, 3'h0);
    stop_test();
  end
endmodule
`default_nettype wire
